/* File: common/sdi_stress_pkg.sv */
package sdi_stress_pkg;
  // pattern select codes
  localparam logic [3:0] PAT_COSITE = 4'h0;
  localparam logic [3:0] PAT_CHECK_FULL = 4'h1;
  localparam logic [3:0] PAT_CHECK_HALF = 4'h2;
  localparam logic [3:0] PAT_MATRIX_HALF = 4'h3;
  localparam logic [3:0] PAT_MATRIX_HD_BARS = 4'h4;
  localparam logic [3:0] PAT_MATRIX_UHD_BARS = 4'h5;
  localparam logic [3:0] PAT_EQ_FULL = 4'h6;
  localparam logic [3:0] PAT_EQ_HALF = 4'h7;
  localparam logic [3:0] PAT_PLL_FULL = 4'h8;
  localparam logic [3:0] PAT_PLL_HALF = 4'h9;
  localparam logic [3:0] PAT_BANDWIDTH = 4'ha;
  // format class codes
  localparam logic [1:0] FMT_SD = 2'h0;
  localparam logic [1:0] FMT_HD = 2'h1;
  localparam logic [1:0] FMT_UHD = 2'h2;
  // sampling codes
  localparam logic [1:0] SMP_YCC422_10 = 2'h0;
  localparam logic [1:0] SMP_OTHER_10 = 2'h1;
  localparam logic [1:0] SMP_12BIT = 2'h2;
  // stress words
  localparam logic [9:0] EQ_FULL_A = 10'h300;
  localparam logic [9:0] EQ_FULL_B = 10'h198;
  localparam logic [9:0] PLL_FULL_A = 10'h200;
  localparam logic [9:0] PLL_FULL_B = 10'h110;
  localparam logic [9:0] EQ_HALF_W = 10'h14c;
  localparam logic [9:0] PLL_HALF_W = 10'h218;
  localparam logic [9:0] BW_HALF_W = 10'h277;
  // co-siting pulse levels, one per channel, and base black
  localparam logic [9:0] COSITE_Y = 10'h3ac;
  localparam logic [9:0] COSITE_CB = 10'h300;
  localparam logic [9:0] COSITE_CR = 10'h100;
  localparam logic [9:0] BLACK_Y = 10'h040;
  localparam logic [9:0] BLACK_C = 10'h200;
  // narrow-range 100% bar levels, white yellow cyan green magenta red blue black
  localparam logic [79:0] BAR_Y_HD =
    {10'h3ac, 10'h3a8, 10'h2fd, 10'h2f9, 10'h0c0, 10'h0bc, 10'h040, 10'h040};
  localparam logic [79:0] BAR_CB_HD =
    {10'h200, 10'h040, 10'h2a4, 10'h0e4, 10'h31c, 10'h15c, 10'h3c0, 10'h200};
  localparam logic [79:0] BAR_CR_HD =
    {10'h200, 10'h212, 10'h040, 10'h052, 10'h3ae, 10'h3c0, 10'h1ee, 10'h200};
  localparam logic [79:0] BAR_Y_UHD =
    {10'h3ac, 10'h3a3, 10'h31b, 10'h312, 10'h0d3, 10'h0ca, 10'h040, 10'h040};
  localparam logic [79:0] BAR_CB_UHD =
    {10'h200, 10'h040, 10'h276, 10'h0b6, 10'h34a, 10'h18a, 10'h3c0, 10'h200};
  localparam logic [79:0] BAR_CR_UHD =
    {10'h200, 10'h22a, 10'h040, 10'h06a, 10'h396, 10'h3c0, 10'h1d6, 10'h200};
  localparam int BAR_COUNT = 8;
  localparam logic [9:0] POL_RESET = 10'h000;
endpackage : sdi_stress_pkg

/* File: logic/sdi_stress_pattern_generator.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - co-siting pattern puts a one-sample pulse at centre, distinct level per channel.
// - polarity control word comes from a 10-bit counter, not a toggled bit.
// - full checkfield top half alternates 300h and 198h.
// - full checkfield bottom half alternates 200h and 110h.
// - full checkfield is refused for 2160-line formats.
// - half checkfield works on every format; equalizer half repeats 14Ch.
// - half checkfield PLL half repeats 218h.
// - half matrix is equalizer, PLL, bandwidth thirds from top down.
// - half matrix is refused for 2160-line 12-bit formats.
// - matrix with HD bars only for HD YCbCr 4:2:2 10-bit.
// - matrix with UHD bars only for UHD YCbCr 4:2:2 10-bit.
// - full equalizer fills the field alternating 300h and 198h.
// - half equalizer fills the field with 14Ch.
// - full PLL fills the field alternating 200h and 110h.
// - half PLL fills the field with 218h.
// - bandwidth pattern fills the field with 277h.
// - stress words go out unchanged on all channels, whatever the format.
module sdi_stress_pattern_generator #(
  parameter int X_W = 13,
  parameter int Y_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  // pattern and format selection
  input wire logic [3:0] pattern_sel,
  input wire logic [1:0] format_class,
  input wire logic [1:0] sampling,
  // raster geometry
  input wire logic [X_W-1:0] active_width,
  input wire logic [Y_W-1:0] active_height,
  // raster timing from the video timing generator
  input wire logic frame_start,
  input wire logic active_en,
  input wire logic [X_W-1:0] pix_x,
  input wire logic [Y_W-1:0] pix_y,
  // sample output
  output logic [9:0] y_out,
  output logic [9:0] cb_out,
  output logic [9:0] cr_out,
  output logic sample_valid,
  output logic pattern_ok
);

  // polarity counter
  logic [9:0] pol_count_r;

  // selection state
  logic allowed;
  logic patho;
  logic [9:0] word;

  // raster position decode
  logic odd_x;
  logic top_half;
  logic centre;
  logic first_sample;
  logic [Y_W-1:0] third_h;
  logic [1:0] third_idx;

  // bar layout
  logic [2:0] bar_idx;
  logic use_bars;
  logic uhd_bars;
  logic [X_W-1:0] bar_w;
  logic [X_W-1:0] bar_edge [sdi_stress_pkg::BAR_COUNT];
  logic [sdi_stress_pkg::BAR_COUNT-1:0] past_edge;

  // per-lane level tables: 0 luma, 1 blue difference, 2 red difference
  logic [9:0] black_lvl [3];
  logic [9:0] cosite_lvl [3];
  logic [79:0] bars_hd [3];
  logic [79:0] bars_uhd [3];

  // pattern availability per format
  always_comb begin
    unique case (pattern_sel)
      sdi_stress_pkg::PAT_CHECK_FULL: begin
        // refused for the whole uhd class, the only 2160-line class here
        allowed = (format_class != sdi_stress_pkg::FMT_UHD);
      end
      sdi_stress_pkg::PAT_MATRIX_HALF: begin
        allowed = !(format_class == sdi_stress_pkg::FMT_UHD &&
                    sampling == sdi_stress_pkg::SMP_12BIT);
      end
      sdi_stress_pkg::PAT_MATRIX_HD_BARS: begin
        allowed = (format_class == sdi_stress_pkg::FMT_HD &&
                   sampling == sdi_stress_pkg::SMP_YCC422_10);
      end
      sdi_stress_pkg::PAT_MATRIX_UHD_BARS: begin
        allowed = (format_class == sdi_stress_pkg::FMT_UHD &&
                   sampling == sdi_stress_pkg::SMP_YCC422_10);
      end
      sdi_stress_pkg::PAT_COSITE, sdi_stress_pkg::PAT_CHECK_HALF,
      sdi_stress_pkg::PAT_EQ_FULL, sdi_stress_pkg::PAT_EQ_HALF,
      sdi_stress_pkg::PAT_PLL_FULL, sdi_stress_pkg::PAT_PLL_HALF,
      sdi_stress_pkg::PAT_BANDWIDTH: begin
        allowed = 1'b1;
      end
      default: begin
        // unused codes are refused and come out black
        allowed = 1'b0;
      end
    endcase
  end

  assign patho = (pattern_sel != sdi_stress_pkg::PAT_COSITE);

  // advance once per frame; a wide count reaches both dc polarities reliably
  always_ff @(posedge clk) begin
    if (rst) begin
      pol_count_r <= sdi_stress_pkg::POL_RESET;
    end else if (frame_start) begin
      pol_count_r <= pol_count_r + 10'h001;
    end
  end

  assign odd_x = pix_x[0];
  assign top_half = (pix_y < (active_height >> 1));
  // thirds by integer divide; a remainder of one or two lines joins the bottom
  assign third_h = Y_W'(active_height / 3);
  always_comb begin
    if (pix_y < third_h) begin
      third_idx = 2'h0;
    end else if (pix_y < Y_W'(third_h + third_h)) begin
      third_idx = 2'h1;
    end else begin
      third_idx = 2'h2;
    end
  end

  // bars occupy the bottom third in the matrix-with-bars layouts
  assign use_bars = (pattern_sel == sdi_stress_pkg::PAT_MATRIX_HD_BARS ||
                     pattern_sel == sdi_stress_pkg::PAT_MATRIX_UHD_BARS) &&
                    (third_idx == 2'h2);
  assign uhd_bars = (pattern_sel == sdi_stress_pkg::PAT_MATRIX_UHD_BARS);
  assign bar_w = X_W'(active_width >> 3);

  // every bar edge compared in parallel; the last bar takes any remainder columns
  for (genvar b = 0; b < sdi_stress_pkg::BAR_COUNT; b++) begin : g_bar
    assign bar_edge[b] = X_W'(bar_w * b);
    assign past_edge[b] = (pix_x >= bar_edge[b]);
  end

  always_comb begin
    bar_idx = 3'h7;
    for (int i = 1; i < sdi_stress_pkg::BAR_COUNT; i++) begin
      if (past_edge[i] && bar_w != '0) begin
        bar_idx = 3'(sdi_stress_pkg::BAR_COUNT - 1 - i);
      end
    end
  end

  // special sample positions
  assign centre = (pix_x == X_W'(active_width >> 1)) && (pix_y == Y_W'(active_height >> 1));
  assign first_sample = (pix_x == '0) && (pix_y == '0);

  // level tables, one entry per lane
  assign black_lvl[0] = sdi_stress_pkg::BLACK_Y;
  assign black_lvl[1] = sdi_stress_pkg::BLACK_C;
  assign black_lvl[2] = sdi_stress_pkg::BLACK_C;
  assign cosite_lvl[0] = sdi_stress_pkg::COSITE_Y;
  assign cosite_lvl[1] = sdi_stress_pkg::COSITE_CB;
  assign cosite_lvl[2] = sdi_stress_pkg::COSITE_CR;
  assign bars_hd[0] = sdi_stress_pkg::BAR_Y_HD;
  assign bars_hd[1] = sdi_stress_pkg::BAR_CB_HD;
  assign bars_hd[2] = sdi_stress_pkg::BAR_CR_HD;
  assign bars_uhd[0] = sdi_stress_pkg::BAR_Y_UHD;
  assign bars_uhd[1] = sdi_stress_pkg::BAR_CB_UHD;
  assign bars_uhd[2] = sdi_stress_pkg::BAR_CR_UHD;

  // one stress word for all three channels
  always_comb begin
    word = sdi_stress_pkg::BW_HALF_W;
    unique case (pattern_sel)
      sdi_stress_pkg::PAT_CHECK_FULL: begin
        if (top_half) begin
          word = odd_x ? sdi_stress_pkg::EQ_FULL_B : sdi_stress_pkg::EQ_FULL_A;
        end else begin
          word = odd_x ? sdi_stress_pkg::PLL_FULL_B : sdi_stress_pkg::PLL_FULL_A;
        end
      end
      sdi_stress_pkg::PAT_CHECK_HALF: begin
        word = top_half ? sdi_stress_pkg::EQ_HALF_W : sdi_stress_pkg::PLL_HALF_W;
      end
      sdi_stress_pkg::PAT_MATRIX_HALF, sdi_stress_pkg::PAT_MATRIX_HD_BARS,
      sdi_stress_pkg::PAT_MATRIX_UHD_BARS: begin
        unique case (third_idx)
          2'h0: begin
            word = sdi_stress_pkg::EQ_HALF_W;
          end
          2'h1: begin
            word = sdi_stress_pkg::PLL_HALF_W;
          end
          default: begin
            word = sdi_stress_pkg::BW_HALF_W;
          end
        endcase
      end
      sdi_stress_pkg::PAT_EQ_FULL: begin
        word = odd_x ? sdi_stress_pkg::EQ_FULL_B : sdi_stress_pkg::EQ_FULL_A;
      end
      sdi_stress_pkg::PAT_EQ_HALF: begin
        word = sdi_stress_pkg::EQ_HALF_W;
      end
      sdi_stress_pkg::PAT_PLL_FULL: begin
        word = odd_x ? sdi_stress_pkg::PLL_FULL_B : sdi_stress_pkg::PLL_FULL_A;
      end
      sdi_stress_pkg::PAT_PLL_HALF: begin
        word = sdi_stress_pkg::PLL_HALF_W;
      end
      sdi_stress_pkg::PAT_BANDWIDTH: begin
        word = sdi_stress_pkg::BW_HALF_W;
      end
      default: begin
        word = sdi_stress_pkg::BW_HALF_W;
      end
    endcase
  end

  // one output lane per component; lanes differ only in their level tables
  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic [9:0] chan_nxt;
    logic [9:0] chan_r;

    always_comb begin
      chan_nxt = black_lvl[c];
      if (!allowed || !active_en) begin
        chan_nxt = black_lvl[c];
      end else if (!patho) begin
        if (centre) begin
          chan_nxt = cosite_lvl[c];
        end
      end else if (first_sample) begin
        chan_nxt = pol_count_r;
      end else if (use_bars && uhd_bars) begin
        chan_nxt = bars_uhd[c][bar_idx*10 +: 10];
      end else if (use_bars) begin
        chan_nxt = bars_hd[c][bar_idx*10 +: 10];
      end else begin
        // no colour conversion: the displayed tint depends on the format
        chan_nxt = word;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        chan_r <= black_lvl[c];
      end else begin
        chan_r <= chan_nxt;
      end
    end
  end

  assign y_out = g_chan[0].chan_r;
  assign cb_out = g_chan[1].chan_r;
  assign cr_out = g_chan[2].chan_r;

  // valid follows the raster with the same one-cycle latency as the samples
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= active_en;
    end
  end

  // availability is reported even outside active picture
  always_ff @(posedge clk) begin
    if (rst) begin
      pattern_ok <= 1'b0;
    end else begin
      pattern_ok <= allowed;
    end
  end

endmodule : sdi_stress_pattern_generator

/* File: test/sdi_serializer_model.sv */
`timescale 1ns/100ps
// sink in place of the serializer; scrambling is not modelled, it counts words and keeps the last one
module sdi_serializer_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sample stream
  input wire logic [9:0] word,
  input wire logic valid,
  // accepted word count and the last word taken
  output logic [31:0] n_words,
  output logic [9:0] last_word
);
  always_ff @(posedge clk) begin
    if (rst) n_words <= 32'h0;
    else if (valid) n_words <= n_words + 32'h1;
  end
  always_ff @(posedge clk) begin
    if (rst) last_word <= 10'h000;
    else if (valid) last_word <= word;
  end
endmodule : sdi_serializer_model

/* File: test/sdi_stress_checker.sv */
`timescale 1ns/100ps
module sdi_stress_checker #(
  parameter int X_W = 13,
  parameter int Y_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // selection and raster
  input wire logic [3:0] pattern_sel,
  input wire logic [1:0] format_class,
  input wire logic [1:0] sampling,
  input wire logic frame_start,
  input wire logic active_en,
  input wire logic [X_W-1:0] pix_x,
  input wire logic [Y_W-1:0] pix_y,
  // outputs
  input wire logic [9:0] y_out,
  input wire logic [9:0] cb_out,
  input wire logic [9:0] cr_out,
  input wire logic pattern_ok
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  wire pos0 = ~|pix_x && ~|pix_y;
  wire uhd = format_class == 2'h2;
  wire ycc = sampling == 2'h0;
  property p_flat(logic [3:0] p, logic [9:0] w);
    active_en && pattern_sel == p && !pos0 |=> y_out == w && cb_out == w && cr_out == w;
  endproperty
  // even sample off the first line, then its odd neighbour in the next cycle
  sequence s_pair(logic [3:0] p);
    active_en && pattern_sel == p && !pix_x[0] && pix_y != 0 ##1 active_en && pix_x[0];
  endsequence
  property p_alt(logic [3:0] p, logic [9:0] a, logic [9:0] b);
    s_pair(p) |=> y_out == b && $past(y_out) == a;
  endproperty
  sequence s_first;
    frame_start && active_en && pos0 && pattern_sel == 4'ha;
  endsequence
  AST_EQ_HALF: assert property (p_flat(4'h7, 10'h14c)) else $error("eq half word");
  AST_PLL_HALF: assert property (p_flat(4'h9, 10'h218)) else $error("pll half word");
  AST_BW: assert property (p_flat(4'ha, 10'h277)) else $error("bandwidth word");
  AST_EQ_FULL: assert property (p_alt(4'h6, 10'h300, 10'h198)) else $error("eq alt");
  AST_PLL_FULL: assert property (p_alt(4'h8, 10'h200, 10'h110)) else $error("pll alt");
  AST_POL: assert property (s_first ##1 s_first |=> y_out == $past(y_out) + 10'h1)
    else $error("polarity step");
  AST_CHECK_UHD: assert property (pattern_sel == 4'h1 && uhd |=> !pattern_ok)
    else $error("full checkfield offered");
  AST_MATRIX_12: assert property (pattern_sel == 4'h3 && uhd && sampling == 2'h2 |=> !pattern_ok)
    else $error("matrix offered");
  AST_HD_BARS: assert property (pattern_sel == 4'h4 |=> pattern_ok == $past(format_class == 2'h1 && ycc))
    else $error("hd bars availability");
  AST_UHD_BARS: assert property (pattern_sel == 4'h5 |=> pattern_ok == $past(uhd && ycc))
    else $error("uhd bars availability");
endmodule : sdi_stress_checker
bind sdi_stress_pattern_generator sdi_stress_checker #(.X_W(X_W), .Y_W(Y_W)) u_sdi_stress_checker (
  .clk, .rst, .pattern_sel, .format_class, .sampling, .frame_start, .active_en, .pix_x,
  .pix_y, .y_out, .cb_out, .cr_out, .pattern_ok);

/* File: test/test_sdi_stress_pattern_generator.sv */
`timescale 1ns/100ps
module test_sdi_stress_pattern_generator;
  localparam int W = 16;
  localparam int H = 6;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fs = 1'b0;
  logic act = 1'b0;
  logic [3:0] psel = 4'h0;
  logic [1:0] fmt = 2'h1;
  logic [1:0] smp = 2'h0;
  logic [12:0] px = 13'h0;
  logic [11:0] py = 12'h0;
  logic [9:0] cnt = 10'h0;
  logic [9:0] yo, cbo, cro;
  logic vld, ok;
  logic [31:0] nw;
  logic [9:0] lw;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  sdi_stress_pattern_generator u_sdi_stress_pattern_generator (.clk(clk), .rst(rst),
    .pattern_sel(psel), .format_class(fmt), .sampling(smp), .active_width(13'h10),
    .active_height(12'h6), .frame_start(fs), .active_en(act), .pix_x(px), .pix_y(py),
    .y_out(yo), .cb_out(cbo), .cr_out(cro), .sample_valid(vld), .pattern_ok(ok));
  sdi_serializer_model u_sdi_serializer_model (.clk(clk), .rst(rst), .word(yo),
    .valid(vld), .n_words(nw), .last_word(lw));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // bars take the bottom third; W is a multiple of 8 so no bar absorbs a remainder
  function automatic logic [31:0] expv(logic [3:0] p, int x, int y);
    logic a;
    logic [9:0] w;
    int i;
    a = 1'b1;
    i = 79 - (x / (W / 8)) * 10;
    if (p == 4'h1) a = fmt != 2'h2;
    if (p == 4'h3) a = !(fmt == 2'h2 && smp == 2'h2);
    if (p == 4'h4) a = fmt == 2'h1 && smp == 2'h0;
    if (p == 4'h5) a = fmt == 2'h2 && smp == 2'h0;
    if (p == 4'h0 && x == W / 2 && y == H / 2) return {2'b11, 10'h3ac, 10'h300, 10'h100};
    if (p == 4'h0 || !a) return {1'b1, a, 10'h040, 10'h200, 10'h200};
    if (p == 4'h4 && y >= 2 * (H / 3)) return {2'b11, sdi_stress_pkg::BAR_Y_HD[i-:10],
      sdi_stress_pkg::BAR_CB_HD[i-:10], sdi_stress_pkg::BAR_CR_HD[i-:10]};
    if (p == 4'h5 && y >= 2 * (H / 3)) return {2'b11, sdi_stress_pkg::BAR_Y_UHD[i-:10],
      sdi_stress_pkg::BAR_CB_UHD[i-:10], sdi_stress_pkg::BAR_CR_UHD[i-:10]};
    case (p)
      4'h1: w = y < H / 2 ? (x % 2 ? 10'h198 : 10'h300) : (x % 2 ? 10'h110 : 10'h200);
      4'h2: w = y < H / 2 ? 10'h14c : 10'h218;
      4'h6: w = x % 2 ? 10'h198 : 10'h300;
      4'h7: w = 10'h14c;
      4'h8: w = x % 2 ? 10'h110 : 10'h200;
      4'h9: w = 10'h218;
      4'ha: w = 10'h277;
      default: w = y < H / 3 ? 10'h14c : (y < 2 * (H / 3) ? 10'h218 : 10'h277);
    endcase
    if (x == 0 && y == 0) w = cnt;
    return {2'b11, w, w, w};
  endfunction : expv
  task automatic frame(logic [3:0] p);
    logic [31:0] e;
    psel = p;
    for (int y = 0; y < H; y++) begin
      for (int x = 0; x < W; x++) begin
        fs = x == 0 && y == 0;
        act = 1'b1;
        px = x[12:0];
        py = y[11:0];
        @(posedge clk);
        #1;
        e = expv(p, x, y);
        chk("valid ok", {30'h0, vld, ok}, {30'h0, e[31:30]});
        chk("luma", {22'h0, yo}, {22'h0, e[29:20]});
        chk("chroma", {12'h0, cbo, cro}, {12'h0, e[19:0]});
      end
    end
    fs = 1'b0;
    cnt = cnt + 10'h1;
  endtask : frame
  task automatic t_patterns();
    logic [1:0] fl[4] = '{2'h1, 2'h2, 2'h2, 2'h0};
    logic [1:0] sl[4] = '{2'h0, 2'h0, 2'h2, 2'h1};
    for (int k = 0; k < 4; k++) begin
      fmt = fl[k];
      smp = sl[k];
      for (int p = 0; p < 11; p++) frame(p[3:0]);
    end
    $display("test patterns done");
  endtask : t_patterns
  // back-to-back frame pulses walk the counter through its wrap quickly
  task automatic t_wrap();
    psel = 4'ha;
    px = 13'h0;
    py = 12'h0;
    fs = 1'b1;
    repeat (1025) begin
      @(posedge clk);
      #1;
      chk("polarity", {22'h0, yo}, {22'h0, cnt});
      cnt = cnt + 10'h1;
    end
    fs = 1'b0;
    $display("test polarity done");
  endtask : t_wrap
  task automatic t_reset();
    rst = 1'b1;
    @(posedge clk);
    #1;
    chk("reset", {vld, ok, yo, cbo, cro}, {2'b00, 10'h040, 10'h200, 10'h200});
    rst = 1'b0;
    cnt = 10'h0;
    frame(4'ha);
    act = 1'b0;
    @(posedge clk);
    #1;
    chk("words", nw, 32'h60);
    chk("last word", {22'h0, lw}, {22'h0, 10'h277});
    $display("test reset done");
  endtask : t_reset
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_patterns();
    t_wrap();
    t_reset();
    wrap_up();
  end
endmodule : test_sdi_stress_pattern_generator
